// ==== mpd_pkg.sv ====
// How it works
// - Show message only on enable rise in RUN
// - Priority 0..30, highest triggered message shown
// - New message shown only if strictly higher
// - On removal show highest remaining message
// - Without acknowledge, enable fall removes message
// - With acknowledge, message stays until confirmed
// - Confirm ignored while enable still high
// - Output set exactly while message is set
// - At most ten message instances
// - Edge stamps capture time and date
// - Live time and date refresh every program cycle while a message is shown
// - Editing only when plus sign allows it
// - Cancel held one second enters editing
// - Line selection lands only on parameter lines
// - Cancel plus cursor key is forwarded
// - Up and down keys page between messages
package mpd_pkg;

	// ************************************************
	// Sizes
	// ************************************************
	localparam int unsigned NUM_MSG    = 10;    // Message instances per program
	localparam int unsigned IDX_W      = 4;     // Width of an instance index
	localparam int unsigned PRIO_W     = 5;     // Width of a priority
	localparam logic [4:0]  PRIO_MAX   = 5'h1e; // Highest priority, 30
	localparam int unsigned NUM_LINES  = 4;     // Display lines per message
	localparam int unsigned LINE_W     = 2;     // Width of a line index
	localparam int unsigned STAMP_W    = 16;    // Width of a time or date word

	// ************************************************
	// Reset values
	// ************************************************
	localparam logic [3:0]  IDX_RESET  = 4'h0;  // Shown index after reset
	localparam logic [15:0] STAMP_RESET = 16'h0000; // Stamps after reset

	// ************************************************
	// Timing
	// ************************************************
	localparam int unsigned CLK_HZ       = 125_000_000; // Core clock rate
	localparam int unsigned HOLD_TIME_MS = 1000;        // Least cancel hold time
	localparam int unsigned HOLD_CYCLES_DEF = (CLK_HZ / 1000) * HOLD_TIME_MS; // Least time, exact
	localparam int unsigned HOLD_CNT_W   = 27;          // Width of the hold counter

	// ************************************************
	// Editing states
	// ************************************************
	typedef enum logic [2:0] {
		ED_VIEW   = 3'b001,  // Plain message view
		ED_SELECT = 3'b010,  // Choosing a parameter line
		ED_VALUE  = 3'b100   // Changing the chosen parameter
	} mpd_edit_t;

endpackage : mpd_pkg

// ==== mpd_message_display.sv ====
`timescale 1ns/10ps
module mpd_message_display
	import mpd_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = HOLD_CYCLES_DEF  // Cycles the cancel key must be held
) (
	// Clock and reset
	input  wire logic                           core_clk,
	input  wire logic                           rst,
	// Program state
	input  wire logic                           runMode,       // Module is in RUN
	input  wire logic                           cycleTick,     // One pulse per program cycle
	// Per instance configuration and enable
	input  wire logic [NUM_MSG-1:0]             msgEnable,     // Enable inputs
	input  wire logic [NUM_MSG-1:0]             ackOn,         // Acknowledge required
	input  wire logic [NUM_MSG*PRIO_W-1:0]      msgPrio,       // Priorities, 0..30
	input  wire logic [NUM_MSG-1:0]             editAllowed,   // First line carries a plus
	input  wire logic [NUM_MSG*NUM_LINES-1:0]   paramLineMask, // Lines holding parameters
	// Clock and calendar
	input  wire logic [STAMP_W-1:0]             timeOfDay,
	input  wire logic [STAMP_W-1:0]             dateNow,
	// Operator keys, high while pressed
	input  wire logic                           okKey,
	input  wire logic                           cancelKey,
	input  wire logic                           upKey,
	input  wire logic                           downKey,
	input  wire logic                           leftKey,
	input  wire logic                           rightKey,
	// Message outputs
	output logic [NUM_MSG-1:0]                  msgOut,        // Set while message is set
	// Display
	output logic                                shownValid,
	output logic [IDX_W-1:0]                    shownIdx,
	output logic [STAMP_W-1:0]                  shownTime,
	output logic [STAMP_W-1:0]                  shownDate,
	output logic [STAMP_W-1:0]                  shownEdgeTime,
	output logic [STAMP_W-1:0]                  shownEdgeDate,
	// Editing
	output logic                                editActive,
	output logic                                valueEditing,
	output logic [LINE_W-1:0]                   editLine,
	output logic                                paramCommit,   // One tick pulse on confirm
	// Forwarded cursor keys: up, down, left, right
	output logic [3:0]                          simKey
);

	// ************************************************
	// Declarations
	// ************************************************
	logic [NUM_MSG-1:0]      enPrev;                 // Enable one program cycle ago
	logic [NUM_MSG-1:0]      riseVec;                // Enable rises in RUN
	logic [NUM_MSG-1:0]      fallVec;                // Enable falls
	logic [NUM_MSG-1:0]      ackHit;                 // Confirmed by the operator
	logic [NUM_MSG-1:0]      next_active;            // Message set after this tick
	logic [STAMP_W-1:0]      edgeTimeStamp [NUM_MSG]; // Time at enable rise
	logic [STAMP_W-1:0]      edgeDateStamp [NUM_MSG]; // Date at enable rise
	logic [5:0]              keyPrev;                // Keys at the last tick
	logic                    okRise;
	logic                    cancelRise;
	logic                    upRise;
	logic                    downRise;
	logic                    leftRise;
	logic                    rightRise;
	logic [HOLD_CNT_W-1:0]   holdCnt;                // Cancel hold time counter
	logic                    holdDone;               // Cancel held long enough
	mpd_edit_t               editState;
	logic [NUM_LINES-1:0]    lineMask;               // Parameter lines of shown message
	logic [PRIO_W-1:0]       maxOld;                 // Highest priority already active
	logic                    anyOld;
	logic [IDX_W-1:0]        newIdx;                 // Best of the rising messages
	logic [PRIO_W-1:0]       newPrio;
	logic                    anyNew;
	logic                    newWins;
	logic [IDX_W-1:0]        bestIdx;                // Best of the remaining messages
	logic [PRIO_W-1:0]       bestPrio;
	logic                    anyBest;
	logic                    shownGone;
	logic                    pageReq;
	logic [IDX_W-1:0]        pageIdx;
	logic                    pageHit;
	logic [IDX_W-1:0]        next_shownIdx;
	logic                    next_shownValid;
	logic [LINE_W-1:0]       next_line;
	logic                    lineHit;
	// ************************************************
	// Priority clamp, one per instance
	// ************************************************
	logic [PRIO_W-1:0] prioEff [NUM_MSG]; // Priority limited to 30
	for (genvar g = 0; g < NUM_MSG; g++) begin : g_prio
		assign prioEff[g] = (msgPrio[g*PRIO_W +: PRIO_W] > PRIO_MAX) ? PRIO_MAX : msgPrio[g*PRIO_W +: PRIO_W];
	end
	// ************************************************
	// Edges of enables and keys
	// ************************************************
	assign riseVec    = msgEnable & ~enPrev & {NUM_MSG{runMode}};
	assign fallVec    = ~msgEnable & enPrev;
	assign okRise     = okKey & ~keyPrev[0];
	assign cancelRise = cancelKey & ~keyPrev[1];
	assign upRise     = upKey & ~keyPrev[2];
	assign downRise   = downKey & ~keyPrev[3];
	assign leftRise   = leftKey & ~keyPrev[4];
	assign rightRise  = rightKey & ~keyPrev[5];
	// Enable and key history, updated once per program cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enPrev  <= '0;
			keyPrev <= '0;
		end else if (cycleTick) begin
			enPrev  <= msgEnable;
			keyPrev <= {rightKey, leftKey, downKey, upKey, cancelKey, okKey};
		end
	end

	// ************************************************
	// Message set and clear
	// ************************************************
	// Confirm only a shown, acknowledged message whose enable is low
	always_comb begin
		ackHit = '0;
		for (int i = 0; i < NUM_MSG; i++) begin
			ackHit[i] = okRise && editState == ED_VIEW && shownValid && shownIdx == IDX_W'(i)
			            && ackOn[i] && !msgEnable[i] && msgOut[i];
		end
	end
	// A rise wins over a clear in the same cycle
	assign next_active = riseVec | (msgOut & ~((fallVec & ~ackOn) | ackHit));
	// Message outputs are the message state itself
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			msgOut <= '0;
		end else if (cycleTick) begin
			msgOut <= next_active;
		end
	end
	// Stamps taken at the enable rise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_MSG; i++) begin
				edgeTimeStamp[i] <= STAMP_RESET;
				edgeDateStamp[i] <= STAMP_RESET;
			end
		end else if (cycleTick) begin
			for (int i = 0; i < NUM_MSG; i++) begin
				if (riseVec[i]) begin
					edgeTimeStamp[i] <= timeOfDay;
					edgeDateStamp[i] <= dateNow;
				end
			end
		end
	end
	// ************************************************
	// Priority selection
	// ************************************************
	// Scans: highest of old, of rising and of remaining; ties go to the lower index
	always_comb begin
		maxOld   = '0;
		anyOld   = 1'b0;
		newIdx   = IDX_RESET;
		newPrio  = '0;
		anyNew   = 1'b0;
		bestIdx  = IDX_RESET;
		bestPrio = '0;
		anyBest  = 1'b0;
		for (int i = 0; i < NUM_MSG; i++) begin
			if (msgOut[i] && (!anyOld || prioEff[i] > maxOld)) begin
				maxOld = prioEff[i];
				anyOld = 1'b1;
			end
			if (riseVec[i] && (!anyNew || prioEff[i] > newPrio)) begin
				newPrio = prioEff[i];
				newIdx  = IDX_W'(i);
				anyNew  = 1'b1;
			end
			if (next_active[i] && (!anyBest || prioEff[i] > bestPrio)) begin
				bestPrio = prioEff[i];
				bestIdx  = IDX_W'(i);
				anyBest  = 1'b1;
			end
		end
	end
	// Strictly higher than every active message, or nothing shown yet
	assign newWins   = anyNew && (!anyOld || newPrio > maxOld || !shownValid);
	assign shownGone = shownValid && !next_active[shownIdx];
	// Paging to the next or previous active message
	assign pageReq = (upRise ^ downRise) && !cancelKey && editState == ED_VIEW && shownValid;
	always_comb begin
		pageIdx = shownIdx;
		pageHit = 1'b0;
		for (int k = NUM_MSG - 1; k >= 1; k--) begin
			int j;
			j = upRise ? (int'(shownIdx) + NUM_MSG - k) % NUM_MSG : (int'(shownIdx) + k) % NUM_MSG;
			if (next_active[j]) begin
				pageIdx = IDX_W'(j);
				pageHit = 1'b1;
			end
		end
	end
	// Removal first, then a winning newcomer, then paging
	always_comb begin
		next_shownIdx   = shownIdx;
		next_shownValid = shownValid;
		if (shownGone || !shownValid) begin
			next_shownIdx   = bestIdx;
			next_shownValid = anyBest;
		end else if (newWins) begin
			next_shownIdx   = newIdx;
		end else if (pageReq && pageHit) begin
			next_shownIdx   = pageIdx;
		end
	end
	// Shown message and its fields
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shownValid    <= 1'b0;
			shownIdx      <= IDX_RESET;
			shownTime     <= STAMP_RESET;
			shownDate     <= STAMP_RESET;
			shownEdgeTime <= STAMP_RESET;
			shownEdgeDate <= STAMP_RESET;
		end else if (cycleTick) begin
			shownValid    <= next_shownValid;
			shownIdx      <= next_shownIdx;
			shownTime     <= next_shownValid ? timeOfDay : STAMP_RESET;
			shownDate     <= next_shownValid ? dateNow : STAMP_RESET;
			shownEdgeTime <= next_shownValid ? (riseVec[next_shownIdx] ? timeOfDay : edgeTimeStamp[next_shownIdx])
			                                 : STAMP_RESET;
			shownEdgeDate <= next_shownValid ? (riseVec[next_shownIdx] ? dateNow : edgeDateStamp[next_shownIdx])
			                                 : STAMP_RESET;
		end
	end
	// ************************************************
	// Cancel hold timer
	// ************************************************
	// Counts core cycles while cancel is held in plain view
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			holdCnt  <= '0;
			holdDone <= 1'b0;
		end else if (!cancelKey || editState != ED_VIEW || !shownValid) begin
			holdCnt  <= '0;
			holdDone <= 1'b0;
		end else if (holdCnt >= HOLD_CNT_W'(HOLD_CYCLES - 1)) begin
			holdDone <= 1'b1;
		end else begin
			holdCnt  <= holdCnt + 1'b1;
		end
	end

	// ************************************************
	// Editing
	// ************************************************
	assign lineMask = paramLineMask[shownIdx*NUM_LINES +: NUM_LINES];
	// Next parameter line in the chosen direction, lines without parameters skipped
	always_comb begin
		next_line = editLine;
		lineHit   = 1'b0;
		for (int k = NUM_LINES - 1; k >= 1; k--) begin
			int j;
			j = leftRise ? (int'(editLine) + NUM_LINES - k) % NUM_LINES : (int'(editLine) + k) % NUM_LINES;
			if (lineMask[j]) begin
				next_line = LINE_W'(j);
				lineHit   = 1'b1;
			end
		end
	end
	// Edit state machine, left when the shown message changes
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			editState   <= ED_VIEW;
			editLine    <= '0;
			paramCommit <= 1'b0;
		end else if (cycleTick) begin
			paramCommit <= 1'b0;
			if (!next_shownValid || next_shownIdx != shownIdx) begin
				editState <= ED_VIEW;
			end else begin
				unique case (editState)
					ED_VIEW: begin
						// Long hold, no cursor key, plus sign and a parameter line
						if (holdDone && editAllowed[shownIdx] && |lineMask
						    && !(upKey | downKey | leftKey | rightKey)) begin
							editState <= ED_SELECT;
							editLine  <= lineMask[0] ? '0 : next_line;
						end
					end
					ED_SELECT: begin
						if (cancelRise) begin
							editState <= ED_VIEW;
						end else if (okRise) begin
							editState <= ED_VALUE;
						end else if ((leftRise ^ rightRise) && lineHit) begin
							editLine <= next_line;
						end
					end
					ED_VALUE: begin
						if (okRise) begin
							editState   <= ED_SELECT;
							paramCommit <= 1'b1;
						end else if (cancelRise) begin
							editState <= ED_SELECT;
						end
					end
				endcase
			end
		end
	end
	// Editing flags for the display
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			editActive   <= 1'b0;
			valueEditing <= 1'b0;
		end else begin
			editActive   <= editState != ED_VIEW;
			valueEditing <= editState == ED_VALUE;
		end
	end

	// ************************************************
	// Key forwarding
	// ************************************************
	// Cancel plus cursor key in an active message goes to the program
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			simKey <= '0;
		end else if (cycleTick) begin
			simKey <= (shownValid && cancelKey && editState == ED_VIEW)
			          ? {upKey, downKey, leftKey, rightKey} : 4'h0;
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	a_start_needs_run: assert property (cycleTick && !runMode |=> (msgOut & ~$past(msgOut)) == '0)
		else $error("message started outside RUN");
	a_start_on_rise: assert property (cycleTick && |riseVec |=> (msgOut & $past(riseVec)) == $past(riseVec))
		else $error("rising enable did not start message");
	a_drop_no_ack: assert property (cycleTick && |(fallVec & ~ackOn) |=> (msgOut & $past(fallVec & ~ackOn)) == '0)
		else $error("message kept after enable fell without acknowledge");
	a_keep_for_ack: assert property (cycleTick && !okRise && |(fallVec & ackOn & msgOut)
		|=> (msgOut & $past(fallVec & ackOn & msgOut)) == $past(fallVec & ackOn & msgOut))
		else $error("acknowledged message dropped on enable fall");
	a_ack_blocked_high: assert property (cycleTick |=> ($past(msgOut & msgEnable) & ~msgOut) == '0)
		else $error("message removed while enable high");
	a_shown_is_active: assert property (shownValid |-> msgOut[shownIdx])
		else $error("shown message is not set");
	a_new_visible: assert property (cycleTick && newWins && !shownGone && shownValid |=> shownIdx == $past(newIdx))
		else $error("higher newcomer not shown");
	a_no_steal: assert property (cycleTick && shownValid && !shownGone && !newWins && !pageReq
		|=> $stable(shownIdx))
		else $error("display changed without cause");
	a_edit_needs_hold: assert property ($rose(editActive) |-> $past(holdDone, 2) && editAllowed[shownIdx])
		else $error("editing entered without plus sign or long hold");
	a_line_has_param: assert property (editState != ED_VIEW |-> lineMask[editLine])
		else $error("edit line holds no parameter");
	a_sim_key: assert property (cycleTick && shownValid && cancelKey && editState == ED_VIEW
		|=> simKey == $past({upKey, downKey, leftKey, rightKey}))
		else $error("cursor key not forwarded");
	c_ack_removal: cover property (cycleTick && |ackHit ##1 shownValid);
	c_preempt: cover property (cycleTick && anyOld && newWins ##1 shownValid);
	c_edit_commit: cover property (paramCommit);
	c_page: cover property (cycleTick && pageReq && pageHit);

endmodule : mpd_message_display

// ==== mpd_operator.sv ====
`timescale 1ns/10ps
// ****************************************
// Operator at the display and the keypad
// ****************************************
module mpd_operator (
	// Clock and program cycle
	input  wire logic core_clk,
	input  wire logic cycleTick,
	// Keys, high while pressed
	output logic      okKey,
	output logic      cancelKey,
	output logic      upKey,
	output logic      downKey,
	output logic      leftKey,
	output logic      rightKey
);
	logic [5:0] keys; // Ok, cancel, up, down, left, right

	// Keys rest released
	initial begin
		keys = 6'h00;
	end
	assign {okKey, cancelKey, upKey, downKey, leftKey, rightKey} = keys;

	// Wait for a program cycle edge, then step off it
	task automatic next_tick;
		do @(posedge core_clk); while (cycleTick !== 1'b1);
		#1;
	endtask : next_tick

	// Short press: held for one program cycle, released for the next
	task automatic press(input logic [5:0] mask);
		keys = mask;
		next_tick();
		keys = 6'h00;
		next_tick();
	endtask : press

	// Hold keys for a number of core cycles, then two more cycles of the program
	task automatic hold(input logic [5:0] mask, input int cycles);
		keys = mask;
		repeat (cycles) @(posedge core_clk);
		next_tick();
		next_tick();
	endtask : hold

	// Let go of every key
	task automatic release_all;
		keys = 6'h00;
		next_tick();
	endtask : release_all
endmodule : mpd_operator

// ==== tb_message_priority_display.sv ====
`timescale 1ns/10ps
module tb_message_priority_display;
	import mpd_pkg::*;
	// ****************************************
	// Signals and constants
	// ****************************************
	localparam int unsigned HOLD = 20; // Short cancel hold for simulation
	localparam logic [5:0] K_OK = 6'h20, K_CAN = 6'h10, K_UP = 6'h08;
	localparam logic [5:0] K_DN = 6'h04, K_LT = 6'h02, K_RT = 6'h01;
	logic core_clk, rst, runMode, cycleTick, lastCommit;
	logic [NUM_MSG-1:0] msgEnable, ackOn, editAllowed, msgOut;
	logic [NUM_MSG*PRIO_W-1:0] msgPrio;
	logic [NUM_MSG*NUM_LINES-1:0] paramLineMask;
	logic [STAMP_W-1:0] timeOfDay, dateNow, shownTime, shownDate, shownEdgeTime, shownEdgeDate;
	logic okKey, cancelKey, upKey, downKey, leftKey, rightKey;
	logic shownValid, editActive, valueEditing, paramCommit;
	logic [IDX_W-1:0] shownIdx;
	logic [LINE_W-1:0] editLine;
	logic [3:0] simKey;
	int numErrors, totalChecks, commits;

	// Design and operator
	mpd_message_display #(.HOLD_CYCLES(HOLD)) dut (
		.core_clk(core_clk), .rst(rst), .runMode(runMode), .cycleTick(cycleTick),
		.msgEnable(msgEnable), .ackOn(ackOn), .msgPrio(msgPrio), .editAllowed(editAllowed),
		.paramLineMask(paramLineMask), .timeOfDay(timeOfDay), .dateNow(dateNow),
		.okKey(okKey), .cancelKey(cancelKey), .upKey(upKey), .downKey(downKey),
		.leftKey(leftKey), .rightKey(rightKey), .msgOut(msgOut), .shownValid(shownValid),
		.shownIdx(shownIdx), .shownTime(shownTime), .shownDate(shownDate),
		.shownEdgeTime(shownEdgeTime), .shownEdgeDate(shownEdgeDate), .editActive(editActive),
		.valueEditing(valueEditing), .editLine(editLine), .paramCommit(paramCommit), .simKey(simKey));
	mpd_operator op (
		.core_clk(core_clk), .cycleTick(cycleTick), .okKey(okKey), .cancelKey(cancelKey),
		.upKey(upKey), .downKey(downKey), .leftKey(leftKey), .rightKey(rightKey));

	// ****************************************
	// Clock, program cycle, monitors
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Program cycle every second core cycle
	always @(posedge core_clk) begin
		#1 cycleTick = ~cycleTick;
	end
	// Counts commit pulses
	always @(posedge core_clk) begin
		if (paramCommit === 1'b1 && lastCommit !== 1'b1) commits++;
		lastCommit = paramCommit;
	end
	// Watchdog for a hung run
	initial begin
		#160000;
		numErrors++;
		giveVerdict();
	end

	// ****************************************
	// Compare and helper tasks
	// ****************************************
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic ticks(input int n);
		repeat (n) op.next_tick();
	endtask : ticks
	task automatic giveVerdict;
		$display("checks=%0d errors=%0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : giveVerdict

	// ****************************************
	// Scenarios
	// ****************************************
	// Rise outside and inside RUN, stamps and live fields
	task automatic sc_rise;
		timeOfDay = 16'h1234;
		dateNow = 16'h0a0b;
		msgEnable[2] = 1'b1;
		ticks(2);
		chk_val({6'h00, msgOut}, 16'h0000);
		chk_bit(shownValid, 1'b0);
		msgEnable[2] = 1'b0;
		ticks(1);
		runMode = 1'b1;
		msgEnable[2] = 1'b1;
		ticks(1);
		chk_val({6'h00, msgOut}, 16'h0004);
		chk_val({12'h000, shownIdx}, 16'h0002);
		chk_bit(shownValid, 1'b1);
		chk_val(shownEdgeDate, 16'h0a0b);
		timeOfDay = 16'h1240;
		dateNow = 16'h0a0c;
		ticks(2);
		chk_val(shownTime, 16'h1240);
		chk_val(shownDate, 16'h0a0c);
		chk_val(shownEdgeTime, 16'h1234);
		chk_val(shownEdgeDate, 16'h0a0b);
	endtask : sc_rise
	// Equal priority, paging, top priority, removal
	task automatic sc_prio;
		msgEnable[7] = 1'b1;
		ticks(1);
		chk_val({12'h000, shownIdx}, 16'h0002);
		op.press(K_DN);
		chk_val({12'h000, shownIdx}, 16'h0007);
		op.press(K_UP);
		chk_val({12'h000, shownIdx}, 16'h0002);
		msgEnable[9] = 1'b1;
		ticks(1);
		chk_val({12'h000, shownIdx}, 16'h0009);
		chk_val({6'h00, msgOut}, 16'h0284);
		msgEnable[9] = 1'b0;
		ticks(1);
		chk_val({6'h00, msgOut}, 16'h0084);
		chk_val({12'h000, shownIdx}, 16'h0002);
	endtask : sc_prio
	// Acknowledged message
	task automatic sc_ack;
		ackOn[3] = 1'b1;
		msgEnable[3] = 1'b1;
		ticks(1);
		chk_val({12'h000, shownIdx}, 16'h0003);
		op.press(K_OK);
		chk_val({6'h00, msgOut}, 16'h008c);
		msgEnable[3] = 1'b0;
		ticks(2);
		chk_val({6'h00, msgOut}, 16'h008c);
		op.press(K_OK);
		chk_val({6'h00, msgOut}, 16'h0084);
		chk_val({12'h000, shownIdx}, 16'h0002);
	endtask : sc_ack
	// Cancel plus cursor key forwarding
	task automatic sc_keys;
		op.hold(K_CAN | K_LT, 0);
		chk_val({12'h000, simKey}, 16'h0002);
		op.release_all();
		chk_val({12'h000, simKey}, 16'h0000);
	endtask : sc_keys
	// Editing in the shown message
	task automatic sc_edit;
		op.hold(K_CAN, HOLD + 4);
		op.release_all();
		chk_bit(editActive, 1'b0);
		editAllowed[2] = 1'b1;
		op.hold(K_CAN, 8);
		op.release_all();
		chk_bit(editActive, 1'b0);
		op.hold(K_CAN, HOLD + 4);
		chk_bit(editActive, 1'b1);
		chk_val({14'h0000, editLine}, 16'h0001);
		op.release_all();
		op.press(K_RT);
		chk_val({14'h0000, editLine}, 16'h0003);
		op.press(K_RT);
		chk_val({14'h0000, editLine}, 16'h0001);
		op.press(K_LT);
		chk_val({14'h0000, editLine}, 16'h0003);
		op.press(K_OK);
		chk_bit(valueEditing, 1'b1);
		op.press(K_CAN);
		chk_bit(valueEditing, 1'b0);
		chk_bit(editActive, 1'b1);
		op.press(K_OK);
		op.press(K_OK);
		chk_val(commits[15:0], 16'h0001);
		op.press(K_CAN);
		chk_bit(editActive, 1'b0);
	endtask : sc_edit

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		cycleTick = 1'b0;
		runMode = 1'b0;
		lastCommit = 1'b0;
		{msgEnable, ackOn, editAllowed} = '0;
		msgPrio = '0;
		msgPrio[10+:5] = 5'h05;
		msgPrio[35+:5] = 5'h05;
		msgPrio[15+:5] = 5'h14;
		msgPrio[45+:5] = PRIO_MAX;
		paramLineMask = '0;
		paramLineMask[8+:4] = 4'ha;
		timeOfDay = 16'h0000;
		dateNow = 16'h0000;
		repeat (3) @(posedge core_clk);
		#1 rst = 1'b0;
		sc_rise();
		sc_prio();
		sc_ack();
		sc_keys();
		sc_edit();
		giveVerdict();
	end
endmodule : tb_message_priority_display
